/* dv/host_model.sv */
// Host model: issues status commands and collects read answers.
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Clock.
   input wire logic core_clk,
   // Command out, answer in.
   output var status_groups_pkg::status_cmd_t cmd,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   import status_groups_pkg::*;
   logic late = 1'b0; // Raised when an answer never came.
   initial cmd = '0;
   // One command stands for exactly one taking edge.
   task automatic send(input logic w, input logic q, input logic [2:0] s, input logic [15:0] d);
      @(posedge core_clk);
      #1 cmd = '{1'b1, w, q, s, d};
      @(posedge core_clk);
      #1 cmd.valid = 1'b0;
   endtask : send
   // Read with a bounded wait, since a lost answer must not hang the run.
   task automatic get(input logic q, input logic [2:0] s, output logic [15:0] v);
      int n;
      send(1'b0, q, s, 16'h0000);
      n = 0;
      while (rvalid !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1 n++;
      end
      if (n == 4) late = 1'b1;
      v = rdata;
   endtask : get
endmodule : host_model
`default_nettype wire

/* dv/status_groups_assertions.sv */
// Checker: port-level properties of the status groups.
`timescale 1ns/100ps
`default_nettype none
module status_groups_assertions (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic arst_n,
   // Watched inputs.
   input wire status_groups_pkg::status_cmd_t cmd,
   input wire status_groups_pkg::oper_state_t oper_state,
   // Watched outputs.
   input wire logic [15:0] rdata,
   input wire logic rvalid,
   input wire logic [7:0] status_byte_bits
);
   import status_groups_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   // Expected condition bits, named so that $past sees plain signals.
   wire rd = cmd.valid && !cmd.write;
   wire cal = oper_state.calibrating;
   wire iref = oper_state.internal_ref_in_use;
   wire meas = oper_state.measure_active && !(oper_state.ext_ref_selected && oper_state.ext_ref_bad);
   ////////////////////////////////////////
   // Condition read while the state has held for a cycle, so a registered copy cannot lag.
   sequence s_cond_rd;
      rd && !cmd.group_ques && cmd.sel == SEL_CONDITION && $stable(oper_state);
   endsequence
   a_read_answer: assert property (rd |=> rvalid)
      else $error("read gave no answer");
   a_no_answer: assert property (!rd |=> !rvalid)
      else $error("answer without a read");
   a_bit15_zero: assert property (rvalid |-> !rdata[15])
      else $error("bit 15 read as one");
   a_unused_zero: assert property (rd && !cmd.group_ques |=> (rdata & ~OPER_USED_MASK) == 16'h0000)
      else $error("unused operation bit read as one");
   a_sb_spare: assert property ((status_byte_bits & 8'h77) == 8'h00)
      else $error("spare status byte bit set");
   a_calib_live: assert property (s_cond_rd |=> rdata[BIT_CALIBRATING] == $past(cal))
      else $error("calibrating bit wrong");
   a_measure_gate: assert property (s_cond_rd |=> rdata[BIT_MEASURING] == $past(meas))
      else $error("measuring bit wrong");
   a_intref_live: assert property (s_cond_rd |=> rdata[BIT_INTERNAL_REF] == $past(iref))
      else $error("internal reference bit wrong");
endmodule : status_groups_assertions
`default_nettype wire

/* dv/tb.sv */
// Testbench: register tests of the status groups through the host model.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import status_groups_pkg::*;
   localparam logic OP = 1'b0;
   localparam logic QU = 1'b1;
   logic core_clk = 1'b0, arst_n = 1'b0, clear_status = 1'b0, status_preset = 1'b0, rvalid;
   oper_state_t st = '0;
   logic [15:0] qc = '0, qe = '0, rdata;
   status_cmd_t cmd;
   logic [7:0] sb;
   int n_fail = 0, comparisons = 0;
   initial forever #50 core_clk = ~core_clk;
   status_groups i_status_groups (.core_clk(core_clk), .arst_n(arst_n), .cmd(cmd), .clear_status(clear_status),
      .status_preset(status_preset), .oper_state(st), .ques_condition_in(qc), .ques_event_pulse(qe),
      .rdata(rdata), .rvalid(rvalid), .status_byte_bits(sb));
   host_model i_host_model (.core_clk(core_clk), .cmd(cmd), .rdata(rdata), .rvalid(rvalid));
   ////////////////////////////////////////
   // Compare and count.
   task automatic chk(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h, want %h", $time, g, e);
      end
   endtask : chk
   // Read one register and compare.
   task automatic rd(input logic q, input logic [2:0] s, input logic [15:0] e);
      logic [15:0] x;
      i_host_model.get(q, s, x);
      // A lost answer ends the run at once; report_and_stop counts it as a mismatch.
      if (i_host_model.late) begin
         report_and_stop();
      end else begin
         chk(e, x);
      end
   endtask : rd
   // Wait k edges, then step off the edge.
   task automatic tick(input int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask : tick
   task automatic report_and_stop;
      if (i_host_model.late) n_fail++;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////
   initial begin
      tick(12);
      arst_n = 1'b1;
      tick(3);
      rd(OP, SEL_RISE_FILTER, OPER_USED_MASK);
      rd(QU, SEL_RISE_FILTER, QUES_USED_MASK);
      rd(OP, SEL_FALL_FILTER, 16'h0000);
      rd(QU, SEL_EVENT_ENABLE, 16'h0000);
      i_host_model.send(1'b1, OP, SEL_EVENT_ENABLE, 16'hffff);
      rd(OP, SEL_EVENT_ENABLE, OPER_USED_MASK);
      // All four filter settings against a rise and a fall of the calibrating bit.
      for (int f = 0; f < 4; f++) begin
         i_host_model.send(1'b1, OP, SEL_RISE_FILTER, {15'h0, f[0]});
         i_host_model.send(1'b1, OP, SEL_FALL_FILTER, {15'h0, f[1]});
         st.calibrating = 1'b1;
         tick(3);
         chk({15'h0, f[0]}, {15'h0, sb[7]});
         rd(OP, SEL_EVENT, {15'h0, f[0]});
         st.calibrating = 1'b0;
         tick(3);
         rd(OP, SEL_EVENT, {15'h0, f[1]});
      end
      // The limit event ignores a filter that is off and stays after its pulse.
      st.limit_pass_pulse = 1'b1;
      tick(1);
      st.limit_pass_pulse = 1'b0;
      tick(4);
      chk(16'h0001, {15'h0, sb[7]});
      rd(OP, SEL_EVENT, 16'h0400);
      rd(OP, SEL_EVENT, 16'h0000);
      chk(16'h0000, {15'h0, sb[7]});
      st = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      tick(2);
      rd(OP, SEL_CONDITION, 16'h0300);
      st.ext_ref_bad = 1'b0;
      st.internal_ref_in_use = 1'b0;
      tick(2);
      rd(OP, SEL_CONDITION, 16'h0110);
      rd(OP, SEL_CONDITION, 16'h0110);
      // Questionable conditions: bit 15 never shows, and a rise sets the event.
      qc = 16'h8020;
      tick(2);
      rd(QU, SEL_CONDITION, 16'h0020);
      rd(QU, SEL_EVENT, 16'h0020);
      qc = 16'h0000;
      st = '0;
      i_host_model.send(1'b1, QU, SEL_EVENT_ENABLE, 16'h0004);
      qe = 16'h8004;
      st.limit_pass_pulse = 1'b1;
      tick(1);
      qe = 16'h0000;
      st.limit_pass_pulse = 1'b0;
      tick(3);
      chk(16'h0001, {15'h0, sb[3]});
      chk(16'h0001, {15'h0, sb[7]});
      clear_status = 1'b1;
      tick(1);
      clear_status = 1'b0;
      rd(QU, SEL_EVENT, 16'h0000);
      rd(OP, SEL_EVENT, 16'h0000);
      rd(QU, SEL_RISE_FILTER, QUES_USED_MASK);
      rd(OP, SEL_FALL_FILTER, 16'h0001);
      status_preset = 1'b1;
      tick(1);
      status_preset = 1'b0;
      rd(OP, SEL_EVENT_ENABLE, 16'h0000);
      rd(OP, SEL_RISE_FILTER, OPER_USED_MASK);
      report_and_stop();
   end
endmodule : tb
bind status_groups status_groups_assertions i_status_groups_assertions (.core_clk(core_clk), .arst_n(arst_n),
   .cmd(cmd), .oper_state(oper_state), .rdata(rdata), .rvalid(rvalid), .status_byte_bits(status_byte_bits));
`default_nettype wire

/* logic/status_groups.sv */
// Top: operation and questionable status register groups with summaries.
//
// Overview of operation
// - Two groups, each with condition, rise, fall, event and enable registers.
// - Condition registers follow live state with no latching.
// - Reading a condition register does not change it.
// - Rise filter alone: event set only on condition zero to one.
// - Fall filter alone: event set only on condition one to zero.
// - Both filters set: event set on any condition change.
// - Neither filter set: condition changes never set the event.
// - Clear-status and queries leave transition filters unchanged.
// - Preset and power-on load default values into the transition filters.
// - Event bits stay set until read or cleared.
// - Event query returns then clears; clear-status clears both event registers.
// - Group summary is true when any enabled event bit is set.
// - Preset and power-on clear both event enable registers.
// - Operation bit 0 is one while calibrating.
// - Operation bit 4 is one while a measurement runs.
// - Measuring stays zero when selected external reference is bad.
// - Operation bit 8 is high across a statistics block.
// - Operation bit 9 is one while internal reference is in use.
// - Bit 9 follows both commanded and automatic reference changes.
// - Operation event bit 10 sets on each passing limit test.
// - Filters do not affect the in-limit event bit.
// - Operation bit 15 always reads zero.
// - Operation summary drives status byte bit 7.
// - Questionable summary drives status byte bit 3.
`timescale 1ns/100ps
`default_nettype none
module status_groups (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic arst_n,
   // Host command port and housekeeping commands.
   input wire status_groups_pkg::status_cmd_t cmd,
   input wire logic clear_status,
   input wire logic status_preset,
   // Monitored instrument state.
   input wire status_groups_pkg::oper_state_t oper_state,
   input wire logic [15:0] ques_condition_in,
   input wire logic [15:0] ques_event_pulse,
   // Answers and summaries.
   output logic [15:0] rdata,
   output logic rvalid,
   output logic [7:0] status_byte_bits
);
   import status_groups_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release through two flip-flops.
   logic rst_meta_r;
   logic rst_n_r;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Condition registers: combinational views of live state, never latched.
   logic [15:0] cond [2];
   logic [15:0] prev_cond_r [2];
   logic [15:0] rise_r [2];
   logic [15:0] fall_r [2];
   logic [15:0] event_r [2];
   logic [15:0] enable_r [2];
   logic [15:0] used_mask [2];
   logic [15:0] direct_set [2];
   logic measuring;

   // A bad external reference that was explicitly chosen hides measuring.
   assign measuring = oper_state.measure_active
                      & ~(oper_state.ext_ref_selected & oper_state.ext_ref_bad);

   always_comb begin
      cond[0] = 16'h0000;
      cond[0][BIT_CALIBRATING] = oper_state.calibrating;
      cond[0][BIT_MEASURING] = measuring;
      cond[0][BIT_STATISTICS] = oper_state.stats_block_busy;
      // The reference monitor already reflects commanded and automatic switches.
      cond[0][BIT_INTERNAL_REF] = oper_state.internal_ref_in_use;
      cond[1] = ques_condition_in & QUES_USED_MASK;
      used_mask[0] = OPER_USED_MASK;
      used_mask[1] = QUES_USED_MASK;
      direct_set[0] = 16'h0000;
      // The in-limit bit bypasses the filters and goes straight to the event.
      direct_set[0][BIT_IN_LIMIT] = oper_state.limit_pass_pulse;
      direct_set[1] = ques_event_pulse & QUES_USED_MASK;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-group register decode.
   logic preset_any;
   assign preset_any = status_preset;

   for (genvar g = 0; g < 2; g++) begin : grp
      // Reset branches need a true constant, not the combinational mask array.
      localparam logic [15:0] GRP_USED_MASK = (g == 0) ? OPER_USED_MASK : QUES_USED_MASK;
      logic sel_grp;
      logic wr_rise;
      logic wr_fall;
      logic wr_en;
      logic rd_event;
      logic [15:0] trans_set;
      logic [15:0] cond_mask;

      assign sel_grp = cmd.valid && (cmd.group_ques == (g == 1));
      assign wr_rise = sel_grp && cmd.write && cmd.sel == SEL_RISE_FILTER;
      assign wr_fall = sel_grp && cmd.write && cmd.sel == SEL_FALL_FILTER;
      assign wr_en = sel_grp && cmd.write && cmd.sel == SEL_EVENT_ENABLE;
      assign rd_event = sel_grp && !cmd.write && cmd.sel == SEL_EVENT;
      assign cond_mask = (g == 0) ? OPER_COND_MASK : QUES_USED_MASK;

      // Edge detection gated by the filter pair covers all four filter cases.
      assign trans_set = cond_mask & ((rise_r[g] & cond[g] & ~prev_cond_r[g])
                                    | (fall_r[g] & ~cond[g] & prev_cond_r[g]));

      // Previous condition for edge detection.
      always_ff @(posedge core_clk or negedge rst_n_r) begin
         if (!rst_n_r) begin
            prev_cond_r[g] <= 16'h0000;
         end else begin
            prev_cond_r[g] <= cond[g];
         end
      end

      // Filters: only reset, preset or a direct write changes them, never a query or clear.
      always_ff @(posedge core_clk or negedge rst_n_r) begin
         if (!rst_n_r) begin
            rise_r[g] <= RISE_FILTER_RESET & GRP_USED_MASK;
            fall_r[g] <= FALL_FILTER_RESET;
         end else if (preset_any) begin
            rise_r[g] <= RISE_FILTER_RESET & used_mask[g];
            fall_r[g] <= FALL_FILTER_RESET;
         end else begin
            if (wr_rise) begin
               rise_r[g] <= cmd.wdata & used_mask[g];
            end
            if (wr_fall) begin
               fall_r[g] <= cmd.wdata & used_mask[g];
            end
         end
      end

      // Enable register.
      always_ff @(posedge core_clk or negedge rst_n_r) begin
         if (!rst_n_r) begin
            enable_r[g] <= ENABLE_RESET;
         end else if (preset_any) begin
            enable_r[g] <= ENABLE_RESET;
         end else if (wr_en) begin
            enable_r[g] <= cmd.wdata & used_mask[g];
         end
      end

      // Sticky events; a new event in the clearing cycle survives the clear.
      always_ff @(posedge core_clk or negedge rst_n_r) begin
         if (!rst_n_r) begin
            event_r[g] <= EVENT_RESET;
         end else if (rd_event || clear_status) begin
            event_r[g] <= (trans_set | direct_set[g]) & used_mask[g];
         end else begin
            event_r[g] <= (event_r[g] | trans_set | direct_set[g]) & used_mask[g];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: one cycle after the command, registered answer.
   logic [15:0] rdata_nxt;
   logic gi;
   assign gi = cmd.group_ques;

   always_comb begin
      unique case (cmd.sel)
         SEL_CONDITION: rdata_nxt = cond[gi];
         SEL_RISE_FILTER: rdata_nxt = rise_r[gi];
         SEL_FALL_FILTER: rdata_nxt = fall_r[gi];
         SEL_EVENT: rdata_nxt = event_r[gi];
         SEL_EVENT_ENABLE: rdata_nxt = enable_r[gi];
         default: rdata_nxt = 16'h0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= cmd.valid && !cmd.write;
         if (cmd.valid && !cmd.write) begin
            rdata <= rdata_nxt & used_mask[gi];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Summary bits into the status byte, registered from the present event and enable registers.
   always_ff @(posedge core_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         status_byte_bits <= 8'h00;
      end else begin
         status_byte_bits <= 8'h00;
         status_byte_bits[STB_OPER_BIT] <= |(event_r[0] & enable_r[0]);
         status_byte_bits[STB_QUES_BIT] <= |(event_r[1] & enable_r[1]);
      end
   end
endmodule : status_groups
`default_nettype wire

/* logic/status_groups_pkg.sv */
// Package: register selectors, bit positions, reset values and port structs for the status groups.
`default_nettype none
package status_groups_pkg;
   // Register selectors on the command port.
   localparam logic [2:0] SEL_CONDITION = 3'h0;
   localparam logic [2:0] SEL_RISE_FILTER = 3'h1;
   localparam logic [2:0] SEL_FALL_FILTER = 3'h2;
   localparam logic [2:0] SEL_EVENT = 3'h3;
   localparam logic [2:0] SEL_EVENT_ENABLE = 3'h4;
   // Operation bit positions.
   localparam int BIT_CALIBRATING = 0;
   localparam int BIT_MEASURING = 4;
   localparam int BIT_STATISTICS = 8;
   localparam int BIT_INTERNAL_REF = 9;
   localparam int BIT_IN_LIMIT = 10;
   // Implemented operation bits; all others, bit 15 included, read zero.
   localparam logic [15:0] OPER_USED_MASK = 16'h0711;
   localparam logic [15:0] OPER_COND_MASK = 16'h0311;
   // Questionable group bits are not assigned here; only bit 15 is held at zero.
   localparam logic [15:0] QUES_USED_MASK = 16'h7fff;
   // Values loaded at power-on and on preset; the event value is loaded at power-on only.
   localparam logic [15:0] RISE_FILTER_RESET = 16'hffff;
   localparam logic [15:0] FALL_FILTER_RESET = 16'h0000;
   localparam logic [15:0] ENABLE_RESET = 16'h0000;
   localparam logic [15:0] EVENT_RESET = 16'h0000;
   // Status byte bit positions for the two summaries.
   localparam int STB_QUES_BIT = 3;
   localparam int STB_OPER_BIT = 7;

   // One register command from the host side.
   typedef struct packed {
      logic valid;
      logic write;
      logic group_ques;
      logic [2:0] sel;
      logic [15:0] wdata;
   } status_cmd_t;

   // Live instrument state feeding the operation condition register and the in-limit event bit.
   typedef struct packed {
      logic calibrating;
      logic measure_active;
      logic ext_ref_selected;
      logic ext_ref_bad;
      logic stats_block_busy;
      logic internal_ref_in_use;
      logic limit_pass_pulse;
   } oper_state_t;
endpackage : status_groups_pkg
`default_nettype wire
